// [design/sbt_timer.sv]
// What this block does
// - timer mode: count cycles, wrap at period
// - idle halts timer/sync counter if stop set
// - sync counter: synchronized external rising edges
// - async counter: every external rising edge
// - async counter halts in idle if stop set
// - gated mode: cycles counted while gate high
// - flag on period match and gate fall
// - prescaler divides by 1, 8, 64, 256
// - prescaler cleared: count write, disable, reset
// - disabled prescaler ignores count-write clears
// - control write leaves count untouched
// - hardware sets flag, software clears it
// - sync select zero with clock select set gives asynchronous counting on the external clock
`timescale 1ns/1ps
`include "sbt_cfg.svh"
module sbt_timer #(
  parameter int CYC_DIV = `SBT_TCY_CLKS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  input  wire logic        external_clock_gate_pin,
  output logic             timer_irq
);
  import sbt_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  sbt_bus_e   bus_reg, bus_next;
  logic       wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  sbt_word_t  count_reg, count_next;
  sbt_word_t  period_reg, period_next;
  sbt_word_t  ctl_reg, ctl_next;
  sbt_word_t  status_reg, status_next;
  sbt_word_t  mask_reg, mask_next;
  logic       irq_reg, irq_next;
  logic       pin_s1_reg, pin_s2_reg, pin_prev_reg;
  logic       pend_reg, pend_next;
  logic [$clog2(CYC_DIV+1)-1:0] cyc_reg, cyc_next;

  logic       cyc_en, ext_rise, ext_fall, run, src_tick, pre_tick;
  logic       acc, cnt_wr, ctl_wr, ps_clr, match_evt, gate_evt;
  logic       timer_on, sidl;
  logic [9:0] idx;
  sbt_mode_e  mode;
  logic [7:0] ps_count;

  // ****************************************************************
  // instruction cycle divider and pin synchroniser
  // ****************************************************************
  // one enable pulse per instruction cycle
  assign cyc_en = (cyc_reg == ($bits(cyc_reg))'(CYC_DIV - 1));
  always_comb begin
    cyc_next = cyc_en ? '0 : cyc_reg + 1'b1;
  end

  // the first stage is read only by the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg      <= '0;
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      cyc_reg      <= cyc_next;
      pin_s1_reg   <= external_clock_gate_pin;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  assign ext_rise = pin_s2_reg & ~pin_prev_reg;
  assign ext_fall = ~pin_s2_reg & pin_prev_reg;

  // ****************************************************************
  // mode decode and count source
  // ****************************************************************
  assign timer_on = ctl_reg[`SBT_CTL_ON];
  assign sidl     = ctl_reg[`SBT_CTL_SIDL];

  // gating is only honoured with the internal clock selected
  always_comb begin
    if (!ctl_reg[`SBT_CTL_CS]) begin
      mode = ctl_reg[`SBT_CTL_GATE] ? SBT_MODE_GATED : SBT_MODE_TIMER;
    end else begin
      mode = ctl_reg[`SBT_CTL_SYNC] ? SBT_MODE_SYNC
                                    : SBT_MODE_ASYNC;
    end
  end

  // sync edges wait for the next cycle phase; set wins over consume
  always_comb begin
    pend_next = (pend_reg & ~cyc_en) | ext_rise;
  end

  always_comb begin
    unique case (mode)
      SBT_MODE_TIMER: src_tick = cyc_en;
      SBT_MODE_GATED: src_tick = cyc_en & pin_s2_reg;
      SBT_MODE_SYNC:  src_tick = cyc_en & pend_reg;
      SBT_MODE_ASYNC: src_tick = ext_rise;
    endcase
  end

  // idle stops every mode when asked; only async keeps running asleep
  assign run = timer_on
             & ~(idle_mode & sidl)
             & ~(sleep_mode & (mode != SBT_MODE_ASYNC));

  sbt_prescaler u_ps (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .tick_in  (src_tick & run),
    .enable   (timer_on),
    .clear    (ps_clr),
    .sel      (ctl_reg[`SBT_CTL_PS_HI:`SBT_CTL_PS_LO]),
    .tick_out (pre_tick),
    .ps_count (ps_count)
  );

  // ****************************************************************
  // register bus
  // ****************************************************************
  assign idx    = avs_address[11:2];
  assign acc    = (bus_reg == SBT_BUS_ACK);
  assign cnt_wr = acc & avs_write & (idx == `SBT_IDX_COUNT);
  assign ctl_wr = acc & avs_write & (idx == `SBT_IDX_CONTROL);
  // a halted prescaler is not cleared by a count write
  assign ps_clr = (cnt_wr & timer_on)
                | (ctl_wr & timer_on & ~avs_writedata[`SBT_CTL_ON]);

  // two-phase slave: wait low for exactly one cycle per request
  always_comb begin
    bus_next   = bus_reg;
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    unique case (bus_reg)
      SBT_BUS_WAIT: begin
        if (avs_read || avs_write) begin
          bus_next  = SBT_BUS_ACK;
          wait_next = 1'b0;
          unique case (idx)
            `SBT_IDX_COUNT:   rdata_next = {16'h0000, count_reg};
            `SBT_IDX_PERIOD:  rdata_next = {16'h0000, period_reg};
            `SBT_IDX_CONTROL: rdata_next = {16'h0000, ctl_reg};
            `SBT_IDX_STATUS:  rdata_next = {16'h0000, status_reg};
            `SBT_IDX_MASK:    rdata_next = {16'h0000, mask_reg};
            default:          rdata_next = 32'h0000_0000;
          endcase
        end
      end
      SBT_BUS_ACK: begin
        bus_next = SBT_BUS_WAIT;
      end
    endcase
  end

  // ****************************************************************
  // counter, configuration and flags
  // ****************************************************************
  assign match_evt = pre_tick & (count_reg == period_reg) & ~cnt_wr;
  assign gate_evt  = timer_on & (mode == SBT_MODE_GATED) & ext_fall;

  always_comb begin
    count_next  = count_reg;
    period_next = period_reg;
    ctl_next    = ctl_reg;
    mask_next   = mask_reg;
    status_next = status_reg;
    if (cnt_wr) begin
      count_next = avs_writedata[15:0];
    end else if (pre_tick) begin
      // wrap after the match, not before it
      count_next = (count_reg == period_reg) ? 16'h0000
                                             : count_reg + 16'h0001;
    end
    if (acc && avs_write) begin
      unique case (idx)
        `SBT_IDX_PERIOD:  period_next = avs_writedata[15:0];
        `SBT_IDX_CONTROL: ctl_next = avs_writedata[15:0]
                                     & `SBT_CTL_IMPL;
        `SBT_IDX_MASK:    mask_next = avs_writedata[15:0]
                                      & `SBT_ST_IMPL;
        default:          ;
      endcase
    end
    // read clears only the bits it returned: an event that lands while
    // the read waits for its acknowledge must not be lost unseen
    if (acc && avs_read && idx == `SBT_IDX_STATUS) begin
      status_next = status_reg & ~rdata_reg[15:0];
    end
    if (match_evt) status_next[`SBT_ST_MATCH] = 1'b1;
    if (gate_evt)  status_next[`SBT_ST_GATE]  = 1'b1;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_reg    <= SBT_BUS_WAIT;
      wait_reg   <= 1'b1;
      rdata_reg  <= 32'h0000_0000;
      count_reg  <= `SBT_COUNT_RST;
      period_reg <= `SBT_PERIOD_RST;
      ctl_reg    <= `SBT_CTL_RST;
      status_reg <= 16'h0000;
      mask_reg   <= 16'h0000;
      irq_reg    <= 1'b0;
      pend_reg   <= 1'b0;
    end else begin
      bus_reg    <= bus_next;
      wait_reg   <= wait_next;
      rdata_reg  <= rdata_next;
      count_reg  <= count_next;
      period_reg <= period_next;
      ctl_reg    <= ctl_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
      pend_reg   <= pend_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign timer_irq       = irq_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (pre_tick && count_reg == period_reg && !cnt_wr)
      |=> count_reg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap to zero at period match");

  property p_idle_halt;
    @(posedge sys_clk) disable iff (!rst_n)
    (idle_mode && sidl && !cnt_wr) |=> $stable(count_reg);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("count moved during idle with stop set");

  property p_async_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == SBT_MODE_ASYNC && idle_mode && sidl && ext_rise && !cnt_wr)
      |=> $stable(count_reg);
  endproperty
  a_async_idle: assert property (p_async_idle)
    else $error("async counter advanced in idle with stop set");

  property p_sync_phase;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == SBT_MODE_SYNC && !cyc_en && !cnt_wr) |=> $stable(count_reg);
  endproperty
  a_sync_phase: assert property (p_sync_phase)
    else $error("sync counter advanced off the cycle phase");

  property p_async_edge;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == SBT_MODE_ASYNC && run && ext_rise && ps_count == 8'h00
     && ctl_reg[5:4] == 2'h0 && count_reg != period_reg && !cnt_wr)
      |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_async_edge: assert property (p_async_edge)
    else $error("async counter missed an external edge");

  property p_gate_low;
    @(posedge sys_clk) disable iff (!rst_n)
    (mode == SBT_MODE_GATED && !pin_s2_reg && !cnt_wr)
      |=> $stable(count_reg);
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("gated count advanced with gate low");

  property p_flag_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    (match_evt || gate_evt) && mask_next != 16'h0000
      && (status_next & mask_next) != 16'h0000
      |=> status_reg != 16'h0000 ##0 timer_irq;
  endproperty
  a_flag_irq: assert property (p_flag_irq)
    else $error("event did not set flag and interrupt");

  property p_ps_clear;
    @(posedge sys_clk) disable iff (!rst_n)
    ps_clr |=> ps_count == 8'h00;
  endproperty
  a_ps_clear: assert property (p_ps_clear)
    else $error("prescaler not cleared");

  property p_ps_hold_off;
    @(posedge sys_clk) disable iff (!rst_n)
    (!timer_on && !ctl_wr) |=> $stable(ps_count) ##0 $stable(count_reg)
                               or $past(cnt_wr);
  endproperty
  a_ps_hold_off: assert property (p_ps_hold_off)
    else $error("prescaler or count moved while disabled");

  property p_ctl_keep;
    @(posedge sys_clk) disable iff (!rst_n)
    (ctl_wr && !pre_tick) |=> $stable(count_reg);
  endproperty
  a_ctl_keep: assert property (p_ctl_keep)
    else $error("control write changed the count");

  property p_one_wait;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("waitrequest low for more than one cycle");
endmodule

// [design/sbt_cfg.svh]
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH
// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define SBT_IDX_COUNT   10'h100
`define SBT_IDX_PERIOD  10'h102
`define SBT_IDX_CONTROL 10'h104
`define SBT_IDX_STATUS  10'h106
`define SBT_IDX_MASK    10'h108
// ****************************************************************
// control fields
// ****************************************************************
`define SBT_CTL_ON      15
`define SBT_CTL_SIDL    13
`define SBT_CTL_GATE    6
`define SBT_CTL_PS_HI   5
`define SBT_CTL_PS_LO   4
`define SBT_CTL_SYNC    2
`define SBT_CTL_CS      1
`define SBT_CTL_IMPL    16'ha076
// ****************************************************************
// status fields and reset values
// ****************************************************************
`define SBT_ST_MATCH    0
`define SBT_ST_GATE     1
`define SBT_ST_IMPL     16'h0003
`define SBT_COUNT_RST   16'h0000
`define SBT_PERIOD_RST  16'hffff
`define SBT_CTL_RST     16'h0000
// ****************************************************************
// prescaler terminal counts and instruction cycle length
// ****************************************************************
`define SBT_PS_TERM1    8'h00
`define SBT_PS_TERM8    8'h07
`define SBT_PS_TERM64   8'h3f
`define SBT_PS_TERM256  8'hff
`define SBT_TCY_CLKS    4
`endif

// [design/sbt_pkg.sv]
package sbt_pkg;
  typedef logic [15:0] sbt_word_t;
  typedef logic [1:0]  sbt_ps_t;
  typedef enum logic [1:0] {
    SBT_MODE_TIMER, SBT_MODE_GATED, SBT_MODE_SYNC, SBT_MODE_ASYNC
  } sbt_mode_e;
  typedef enum logic {SBT_BUS_WAIT, SBT_BUS_ACK} sbt_bus_e;
endpackage

// [design/sbt_prescaler.sv]
`timescale 1ns/1ps
`include "sbt_cfg.svh"
module sbt_prescaler (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          tick_in,
  input  wire logic          enable,
  input  wire logic          clear,
  input  wire sbt_pkg::sbt_ps_t sel,
  output logic               tick_out,
  output logic [7:0]         ps_count
);
  import sbt_pkg::*;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] term;

  // terminal count per divide setting
  always_comb begin
    unique case (sel)
      2'h0: term = `SBT_PS_TERM1;
      2'h1: term = `SBT_PS_TERM8;
      2'h2: term = `SBT_PS_TERM64;
      2'h3: term = `SBT_PS_TERM256;
    endcase
  end

  // clear has priority; a halted prescaler simply holds its count
  always_comb begin
    cnt_next = cnt_reg;
    tick_out = 1'b0;
    if (clear) begin
      cnt_next = 8'h00;
    end else if (enable && tick_in) begin
      if (cnt_reg >= term) begin
        cnt_next = 8'h00;
        tick_out = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign ps_count = cnt_reg;

  property p_div8_out;
    @(posedge sys_clk) disable iff (!rst_n)
    (enable && tick_in && !clear && sel == 2'h1 && cnt_reg == 8'h07)
      |-> tick_out ##1 cnt_reg == 8'h00;
  endproperty
  a_div8_out: assert property (p_div8_out)
    else $error("divide by 8 did not fire at count 7");
endmodule

// [sim/sbt_src.sv]
`timescale 1ns/1ps
// ****
// external clock and gate source
// ****
module sbt_src (
  input  wire logic sys_clk,
  output logic      pin
);
  // rests low between bursts so no stray edge is ever counted
  initial pin = 1'b0;
  // n rising edges, each level held h cycles (h >= 2 to be seen)
  task automatic pulses(input int n, input int h);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge sys_clk);
      pin <= ~pin;
      repeat (h - 1) @(posedge sys_clk);
    end
  endtask
  // gate high for g cycles; the falling edge closes the window
  task automatic gate(input int g);
    @(posedge sys_clk);
    pin <= 1'b1;
    repeat (g) @(posedge sys_clk);
    pin <= 1'b0;
  endtask
endmodule

// [sim/sixteen_bit_interval_timer_bench.sv]
`timescale 1ns/1ps
`include "sbt_cfg.svh"
module sixteen_bit_interval_timer_bench;
  import sbt_pkg::*;
  // short instruction cycle keeps the divide-by-256 runs brief
  localparam int CD = 2;
  localparam logic [11:0] A_CNT = {`SBT_IDX_COUNT, 2'b00};
  localparam logic [11:0] A_PER = {`SBT_IDX_PERIOD, 2'b00};
  localparam logic [11:0] A_CTL = {`SBT_IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_ST  = {`SBT_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_MSK = {`SBT_IDX_MASK, 2'b00};
  logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        idle_mode, sleep_mode, pin, timer_irq;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  sbt_word_t   m;
  int          n_errors, comparisons, seed, p;
  sbt_timer #(.CYC_DIV(CD)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .external_clock_gate_pin(pin),
    .timer_irq(timer_irq));
  sbt_src i_src (.sys_clk(sys_clk), .pin(pin));
  // 200 MHz
  always #2.5 sys_clk = ~sys_clk;
  // ****
  // helpers
  // ****
  task automatic final_report();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a,
                     input sbt_word_t d, output sbt_word_t q);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      k++;
      if (k > 40) begin
        n_errors++;
        final_report();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input sbt_word_t d);
    sbt_word_t q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [11:0] a, input sbt_word_t e);
    sbt_word_t q;
    bus(1'b0, a, 16'h0000, q);
    check(q, e);
  endtask
  function automatic sbt_word_t ctl(input sbt_ps_t ps, input bit sidl,
                                    input bit gt, input bit sy,
                                    input bit cs);
    return {1'b1, 1'b0, sidl, 6'h00, gt, ps, 1'b0, sy, cs, 1'b0};
  endfunction
  // codes 0..3 divide by 1, 8, 64, 256
  function automatic int div_of(input sbt_ps_t ps);
    return 1 << ((ps == 2'h3) ? 8 : 3 * ps);
  endfunction
  // n source events, e count steps expected; timer and gated modes allow
  // one step of slack since the prescaler phase is not visible
  task automatic run(input sbt_word_t c, input int p, input int n,
                     input int e);
    sbt_word_t   q;
    logic [15:0] st;
    logic        ok;
    int          tol;
    tol = (c[1] === 1'b1) ? 0 : 1;
    st = {14'h0000, c[6], e > p};
    wr(A_PER, 16'(p));
    wr(A_CNT, 16'h0000);
    wr(A_CTL, c);
    if (c[1]) i_src.pulses(n, 4);
    else if (c[6]) i_src.gate(n * CD);
    if (c[1] | c[6]) repeat (6) @(posedge sys_clk);
    else repeat (n * CD * div_of(c[5:4]) - 3) @(posedge sys_clk);
    wr(A_CTL, 16'h0000);
    bus(1'b0, A_CNT, 16'h0000, q);
    ok = 1'b0;
    for (int i = -tol; i <= tol; i++)
      if (q === 16'((e + i) % (p + 1))) ok = 1'b1;
    check(16'(ok), 16'h0001);
    check(16'(timer_irq), 16'(|(st & m)));
    rdchk(A_ST, st);
    rdchk(A_ST, 16'h0000);
    check(16'(timer_irq), 16'h0000);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0000_0000;
    idle_mode = 1'b0;
    sleep_mode = 1'b0;
    m = 16'h0000;
    seed = 1657;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, unmapped place, write-ignored control bits
    rdchk(A_CNT, `SBT_COUNT_RST);
    rdchk(A_PER, `SBT_PERIOD_RST);
    rdchk(A_CTL, `SBT_CTL_RST);
    rdchk(A_ST, 16'h0000);
    rdchk(A_MSK, 16'h0000);
    wr(12'h7fc, 16'hffff);
    rdchk(12'h7fc, 16'h0000);
    wr(A_CNT, 16'h1234);
    wr(A_CTL, 16'h7fff);
    rdchk(A_CTL, 16'h7fff & `SBT_CTL_IMPL);
    rdchk(A_CNT, 16'h1234);
    m = 16'h0001;
    wr(A_MSK, m);
    rdchk(A_MSK, m);
    // every prescale code in timer mode, random period, forced wrap
    for (int ps = 0; ps < 4; ps++) begin
      p = 2 + ($unsigned($random(seed)) % 4);
      run(ctl(sbt_ps_t'(ps), 0, 0, 0, 0), p, p + 2, p + 2);
    end
    // idle halts only when stop_in_idle is set
    idle_mode <= 1'b1;
    run(ctl(0, 1, 0, 0, 0), p, p + 2, 0);
    run(ctl(0, 0, 0, 0, 0), p, p + 2, p + 2);
    run(ctl(0, 1, 0, 1, 1), p, p + 2, 0);
    run(ctl(0, 1, 0, 0, 1), p, p + 2, 0);
    idle_mode <= 1'b0;
    // in sleep only the asynchronous counter keeps going
    sleep_mode <= 1'b1;
    run(ctl(0, 0, 0, 0, 0), p, p + 2, 0);
    run(ctl(0, 0, 0, 0, 1), p, p + 2, p + 2);
    sleep_mode <= 1'b0;
    // masked match: status sets but the interrupt stays low; a disabled timer neither counts nor flags
    m = 16'h0000;
    wr(A_MSK, m);
    run(ctl(0, 0, 0, 0, 1), p, p + 2, p + 2);
    run(ctl(1, 0, 0, 1, 1), p, 8 * (p + 2), p + 2);
    run(16'h0010, p, p + 2, 0);
    // gated accumulation on the internal clock only
    m = 16'h0002;
    wr(A_MSK, m);
    run(ctl(0, 0, 1, 0, 0), 65535, 20, 20);
    // repeated count writes clear the divide-by-8 prescaler before it fires, so the count stays zero
    wr(A_CTL, ctl(1, 0, 0, 0, 0));
    repeat (6) begin
      repeat (8) @(posedge sys_clk);
      wr(A_CNT, 16'h0000);
    end
    repeat (10) @(posedge sys_clk);
    rdchk(A_CNT, 16'h0000);
    wr(A_CTL, 16'h0000);
    // a second reset in mid-run restores the period
    wr(A_PER, 16'h0005);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(A_PER, `SBT_PERIOD_RST);
    final_report();
  end
endmodule
